/* File: pkg/cac_pkg.sv */
// Constants and types for the counter arm and reset control block
package cac_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_TICK_CYC   = CLK_HZ / MS_PER_S;

  // Display-time delays in milliseconds
  localparam logic [7:0]  REMOTE_DELAY_MS   = 8'h50;  // 80 ms
  localparam logic [7:0]  FAST_DELAY_MS     = 8'h05;  // 5 ms
  localparam logic [7:0]  TOTALIZE_DELAY_MS = 8'h50;  // 80 ms
  localparam logic [7:0]  MIN_DELAY_MS      = 8'h01;

  // Scaler digits and gate codes
  localparam logic [3:0]  DIGIT_END         = 4'h5;
  localparam logic [3:0]  DIGIT_TO_ARM      = 4'h8;
  localparam logic [3:0]  MIN_GATE_CODE     = 4'hD;
  localparam logic [3:0]  FIRST_TIME_DECADE = 4'h2;

  // Timeout: 3.6 gate lengths, one gate length is five digit steps
  localparam int unsigned TIMEOUT_TENTHS    = 36;
  localparam int unsigned STEPS_PER_GATE    = 5;
  localparam int unsigned TIMEOUT_STEPS     =
    TIMEOUT_TENTHS * STEPS_PER_GATE / 10;
  localparam logic [4:0]  TO_RELOAD         =
    5'(TIMEOUT_STEPS - 32'(DIGIT_TO_ARM));

  // Master reset length, also the power-on reset length
  localparam logic [3:0]  RESET_HOLD        = 4'h8;

  // Layout of the synchronised input vector
  localparam int unsigned SYN_W       = 20;
  localparam int unsigned B_GATE      = 0;   // 4 bits
  localparam int unsigned B_DPOS      = 4;   // 3 bits
  localparam int unsigned B_FUNC      = 7;   // 3 bits
  localparam int unsigned SEL_W       = 10;
  localparam int unsigned B_PDATA     = 10;
  localparam int unsigned B_TOTAL     = 11;
  localparam int unsigned B_REMOTE    = 12;
  localparam int unsigned B_PCLR      = 13;
  localparam int unsigned B_RCLR      = 14;
  localparam int unsigned B_RBTN      = 15;
  localparam int unsigned B_EXTARM    = 16;
  localparam int unsigned B_PARM      = 17;
  localparam int unsigned B_FAST      = 18;
  localparam int unsigned B_DISPEN    = 19;

  // Measurement phases
  typedef enum logic [2:0] {
    CAC_IDLE = 3'b001,
    CAC_GATE = 3'b010,
    CAC_SHOW = 3'b100
  } cac_meas_t;

endpackage : cac_pkg

/* File: rtl/cac_sync.sv */
// Two-stage synchroniser, one stage pair per bit
`timescale 1ns/1ps
module cac_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // Per-bit flop pair; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic hold_ff;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff <= 1'b0;
          hold_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[gi];
          hold_ff <= meta_ff;
        end
      end
      assign sync_out[gi] = hold_ff;
    end
  endgenerate

endmodule : cac_sync

/* File: rtl/cac_top.sv */
// Measurement arming, gate end detection, timeout and reset combining
//
// How it works
// - While accumulating, exactly one time-scaler decade stays selected.
// - First decade takes its low bit from the auxiliary binary stage.
// - Period over 3.6 gate lengths aborts with reset and lamp test.
// - Timeout arms on digit 8, trips at 3.6 gate lengths, latches.
// - Arm from delay expiry, plug-in, external or reset end.
// - Display timer enable starts display delay; expiry arms next cycle.
// - Remote operation uses an 80 ms display delay, 5 ms with fast arm.
// - Fast arm sets a 5 ms display delay; totalize takes 80 ms over it.
// - First-cycle flag set by reset, arms at reset end, clears later.
// - Rate arm pulses on plug-in arm, reset, or display delay expiry.
// - Plug-in or totalize start processing from rate arm, not digit 5.
// - All reset sources merge into one master reset, with power-on.
// - Local selector changes or button reset; clears and timeout always.
// - Reset clears annunciator recheck flag; multiplier strobe sets it.
// - Gate code 13 drives single-cycle gate and blocks digit-5 stop.
// - Digit 5 from the selected decade closes the main gate.
// - Accumulate phase high while counting, low once the gate closes.
`timescale 1ns/1ps
module cac_top #(
  parameter int unsigned MS_TICK = cac_pkg::MS_TICK_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       display_timer_enable,
  input  wire logic       fast_arm_request,
  input  wire logic       plugin_arm_request,
  input  wire logic       external_arm_request,
  input  wire logic       reset_button,
  input  wire logic       remote_clear,
  input  wire logic       plugin_clear,
  input  wire logic       remote_mode,
  input  wire logic       totalize_select,
  input  wire logic       plugin_data_flag,
  input  wire logic [2:0] function_code,
  input  wire logic [2:0] display_position,
  input  wire logic [3:0] gate_setting_code,
  input  wire logic [7:0] rate_setting_ms,
  input  wire logic [3:0] decade_bits,
  input  wire logic       aux_lsb,
  input  wire logic [3:0] readout_address,
  input  wire logic       single_cycle_done,
  input  wire logic       multiplier_store_strobe,
  output logic      [3:0] decade_select_ff,
  output logic            main_gate_open_ff,
  output logic            accumulate_phase_ff,
  output logic            single_cycle_gate_ff,
  output logic            rate_arm_ff,
  output logic            processor_start_ff,
  output logic            lamp_test_ff,
  output logic            master_reset_ff,
  output logic            annunciator_recheck_ff
);

  logic                      rst_a_ff;
  logic                      rst_n_ff;
  logic [cac_pkg::SYN_W-1:0] raw;
  logic [cac_pkg::SYN_W-1:0] s;
  logic [cac_pkg::SYN_W-1:0] s_prev_ff;
  logic [cac_pkg::SYN_W-1:0] rise;
  cac_pkg::cac_meas_t        state_ff;
  logic [3:0]                digit_ff;
  logic [3:0]                nxt_digit;
  logic [17:0]               ms_cnt_ff;
  logic                      ms_tick;
  logic [7:0]                delay_ff;
  logic [7:0]                nxt_delay_load;
  logic                      delay_run_ff;
  logic                      delay_expire;
  logic                      to_armed_ff;
  logic [4:0]                to_cnt_ff;
  logic                      excess;
  logic [3:0]                rst_cnt_ff;
  logic                      reset_req;
  logic                      mreset_prev_ff;
  logic                      first_cycle_ff;
  logic                      first_arm;
  logic                      arm;
  logic                      rate_arm_now;
  logic                      proc_by_arm;
  logic                      min_gate;
  logic                      gate_close;
  logic                      fast;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  // Synchronise front-panel, remote and plug-in controls, except the panel rate setting
  assign raw = {display_timer_enable, fast_arm_request, plugin_arm_request,
                external_arm_request, reset_button, remote_clear,
                plugin_clear, remote_mode, totalize_select,
                plugin_data_flag, function_code, display_position,
                gate_setting_code};

  cac_sync #(.W(cac_pkg::SYN_W)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n_ff),
    .async_in (raw),
    .sync_out (s)
  );

  // Previous values for edge and change detection
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s_prev_ff <= '0;
    end else begin
      s_prev_ff <= s;
    end
  end

  assign rise     = s & ~s_prev_ff;
  assign min_gate = s[cac_pkg::B_GATE +: 4] == cac_pkg::MIN_GATE_CODE;
  assign fast     = s[cac_pkg::B_FAST] | s[cac_pkg::B_TOTAL];

  // Decade address: gate decade while counting, readout address otherwise.
  // The gate decade is loaded on the arming edge too, so that the first
  // counting cycle already watches the right decade.
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      decade_select_ff <= 4'h0;
    end else if (accumulate_phase_ff ||
                 (state_ff != cac_pkg::CAC_GATE && arm)) begin
      decade_select_ff <= s[cac_pkg::B_GATE +: 4];
    end else begin
      decade_select_ff <= readout_address;
    end
  end

  // Scaler digit, first decade low bit from auxiliary stage
  always_comb begin
    nxt_digit = decade_bits;
    if (decade_select_ff == cac_pkg::FIRST_TIME_DECADE) begin
      nxt_digit = {decade_bits[3:1], aux_lsb};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      digit_ff <= 4'h0;
    end else begin
      digit_ff <= nxt_digit;
    end
  end

  // Gate end: digit 5 unless single-cycle gate owns the gate
  assign gate_close = (state_ff == cac_pkg::CAC_GATE) &&
    (min_gate ? single_cycle_done
              : digit_ff == cac_pkg::DIGIT_END);

  // Millisecond tick divider
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ms_cnt_ff <= '0;
    end else if (ms_tick) begin
      ms_cnt_ff <= '0;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 18'h00001;
    end
  end
  assign ms_tick = ms_cnt_ff == 18'(MS_TICK - 1);

  // Display delay reload: totalize, fast, remote or panel rate
  always_comb begin
    if (s[cac_pkg::B_TOTAL]) begin
      nxt_delay_load = cac_pkg::TOTALIZE_DELAY_MS;
    end else if (fast) begin
      nxt_delay_load = cac_pkg::FAST_DELAY_MS;
    end else if (s[cac_pkg::B_REMOTE]) begin
      nxt_delay_load = cac_pkg::REMOTE_DELAY_MS;
    end else if (rate_setting_ms == 8'h00) begin
      nxt_delay_load = cac_pkg::MIN_DELAY_MS;
    end else begin
      nxt_delay_load = rate_setting_ms;
    end
  end

  // Display delay down-counter started by display timer enable
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      delay_ff     <= 8'h00;
      delay_run_ff <= 1'b0;
    end else if (master_reset_ff) begin
      delay_run_ff <= 1'b0;
    end else if (rise[cac_pkg::B_DISPEN]) begin
      delay_ff     <= nxt_delay_load;
      delay_run_ff <= 1'b1;
    end else if (delay_run_ff && ms_tick) begin
      delay_ff     <= delay_ff - 8'h01;
      delay_run_ff <= delay_ff != 8'h01;
    end
  end
  assign delay_expire = delay_run_ff && ms_tick && delay_ff == 8'h01;

  // Arm sources and rate arm
  assign first_arm    = first_cycle_ff && mreset_prev_ff && !master_reset_ff;
  assign arm          = !master_reset_ff && (delay_expire | first_arm |
    rise[cac_pkg::B_PARM] | rise[cac_pkg::B_EXTARM]);
  assign rate_arm_now = rise[cac_pkg::B_PARM] | delay_expire |
    (master_reset_ff && !mreset_prev_ff);
  assign proc_by_arm  = s[cac_pkg::B_PDATA] | s[cac_pkg::B_TOTAL];

  // Measurement phase sequencer
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff            <= cac_pkg::CAC_IDLE;
      main_gate_open_ff   <= 1'b0;
      accumulate_phase_ff <= 1'b0;
    end else if (master_reset_ff) begin
      state_ff            <= cac_pkg::CAC_IDLE;
      main_gate_open_ff   <= 1'b0;
      accumulate_phase_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        cac_pkg::CAC_IDLE, cac_pkg::CAC_SHOW: begin
          if (arm) begin
            state_ff            <= cac_pkg::CAC_GATE;
            main_gate_open_ff   <= 1'b1;
            accumulate_phase_ff <= 1'b1;
          end
        end
        cac_pkg::CAC_GATE: begin
          if (gate_close) begin
            state_ff            <= cac_pkg::CAC_SHOW;
            main_gate_open_ff   <= 1'b0;
            accumulate_phase_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // Rate arm and processor start pulses
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rate_arm_ff        <= 1'b0;
      processor_start_ff <= 1'b0;
    end else begin
      rate_arm_ff        <= rate_arm_now;
      processor_start_ff <= proc_by_arm ? rate_arm_now
                                        : gate_close;
    end
  end

  // Excess gate time timeout, counted in digit steps
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      to_armed_ff <= 1'b0;
      to_cnt_ff   <= 5'h00;
    end else if (state_ff != cac_pkg::CAC_GATE || master_reset_ff) begin
      to_armed_ff <= 1'b0;
    end else if (!to_armed_ff) begin
      if (digit_ff == cac_pkg::DIGIT_TO_ARM) begin
        to_armed_ff <= 1'b1;
        to_cnt_ff   <= cac_pkg::TO_RELOAD;
      end
    end else if (nxt_digit != digit_ff && to_cnt_ff != 5'h00) begin
      to_cnt_ff <= to_cnt_ff - 5'h01;
    end
  end
  assign excess = to_armed_ff && to_cnt_ff == 5'h00;

  // Lamp test latch, held until the next measurement is armed
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lamp_test_ff <= 1'b0;
    end else if (excess) begin
      lamp_test_ff <= 1'b1;
    end else if (arm) begin
      lamp_test_ff <= 1'b0;
    end
  end

  // Reset sources; local ones only outside remote operation
  assign reset_req = excess | rise[cac_pkg::B_RCLR] |
    rise[cac_pkg::B_PCLR] | (!s[cac_pkg::B_REMOTE] &&
    (rise[cac_pkg::B_RBTN] || s[cac_pkg::SEL_W-1:0] !=
     s_prev_ff[cac_pkg::SEL_W-1:0]));

  // Master reset stretcher; reset value gives the power-on reset
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rst_cnt_ff      <= cac_pkg::RESET_HOLD;
      master_reset_ff <= 1'b1;
      mreset_prev_ff  <= 1'b1;
    end else begin
      if (reset_req) begin
        rst_cnt_ff <= cac_pkg::RESET_HOLD;
      end else if (rst_cnt_ff != 4'h0) begin
        rst_cnt_ff <= rst_cnt_ff - 4'h1;
      end
      master_reset_ff <= reset_req || rst_cnt_ff > 4'h1;
      mreset_prev_ff  <= master_reset_ff;
    end
  end

  // First-cycle arm flag
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      first_cycle_ff <= 1'b1;
    end else if (master_reset_ff) begin
      first_cycle_ff <= 1'b1;
    end else if (state_ff == cac_pkg::CAC_GATE && gate_close) begin
      first_cycle_ff <= 1'b0;
    end
  end

  // Single-cycle gate output and annunciator recheck flag
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      single_cycle_gate_ff   <= 1'b0;
      annunciator_recheck_ff <= 1'b0;
    end else begin
      single_cycle_gate_ff <= min_gate;
      if (master_reset_ff) begin
        annunciator_recheck_ff <= 1'b0;
      end else if (multiplier_store_strobe) begin
        annunciator_recheck_ff <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_ff);

  decade_hold_a: assert property (accumulate_phase_ff
    |-> decade_select_ff == $past(s[cac_pkg::B_GATE +: 4]))
    else $error("decade select lost while counting");
  aux_bit_a: assert property (decade_select_ff ==
    cac_pkg::FIRST_TIME_DECADE |=> digit_ff[0] == $past(aux_lsb))
    else $error("first decade low bit not from auxiliary stage");
  timeout_trip_a: assert property (excess |=> lamp_test_ff ##0
    master_reset_ff)
    else $error("timeout did not latch lamp test and reset");
  gate_end_a: assert property (gate_close |=> !main_gate_open_ff
    && !accumulate_phase_ff)
    else $error("gate stayed open after end digit");
  min_gate_a: assert property (min_gate |=> single_cycle_gate_ff)
    else $error("single-cycle gate output missing");
  recheck_set_a: assert property (multiplier_store_strobe &&
    !master_reset_ff |=> annunciator_recheck_ff)
    else $error("recheck flag not set by store strobe");
  clear_reset_a: assert property ($rose(s[cac_pkg::B_RCLR])
    |=> master_reset_ff [*4])
    else $error("remote clear did not hold master reset");
  first_arm_a: assert property (first_cycle_ff &&
    $fell(master_reset_ff) |=> state_ff == cac_pkg::CAC_GATE)
    else $error("first-cycle arm missing after reset");
  proc_arm_a: assert property (rate_arm_now && proc_by_arm
    |=> processor_start_ff && rate_arm_ff)
    else $error("processor start not from rate arm");

endmodule : cac_top

/* File: test/cac_scaler_model.sv */
// Time-scaler decade model with its auxiliary binary stage
`timescale 1ns/1ps
module cac_scaler_model #(
  parameter int unsigned STEP = 4
) (
  input  wire logic       core_clk,
  input  wire logic       gate_open,
  input  wire logic [3:0] decade_select,
  output logic      [3:0] decade_bits,
  output logic            aux_lsb,
  output logic      [3:0] digit_ff
);
  logic [7:0] step_cnt_ff;
  logic       first_sel;

  // Digit steps every STEP cycles while the gate is open
  always_ff @(posedge core_clk) begin
    if (!gate_open) begin
      digit_ff    <= 4'h0;
      step_cnt_ff <= 8'h00;
    end else if (step_cnt_ff == 8'(STEP - 1)) begin
      step_cnt_ff <= 8'h00;
      digit_ff    <= (digit_ff == 4'h9) ? 4'h0 : digit_ff + 4'h1;
    end else begin
      step_cnt_ff <= step_cnt_ff + 8'h01;
    end
  end

  // First decade's own low bit is wrong; only the aux stage carries it
  assign first_sel   = (decade_select == cac_pkg::FIRST_TIME_DECADE);
  assign decade_bits = {digit_ff[3:1], digit_ff[0] ^ first_sel};
  assign aux_lsb     = digit_ff[0] ^ ~first_sel;
endmodule : cac_scaler_model

/* File: test/cac_top_bench.sv */
// Self-checking bench for arming, gate end, timeout and reset sources
`timescale 1ns/1ps
module cac_top_bench;
  localparam int TICK = 20;
  localparam int STEP = 4;
  localparam int TRIP = 10 * STEP;

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  bad_count++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
  end end

  logic       core_clk, nrst, display_timer_enable, fast_arm_request;
  logic       remote_mode, totalize_select, plugin_data_flag;
  logic       aux_lsb, single_cycle_done, multiplier_store_strobe;
  logic [2:0] function_code, display_position;
  logic [3:0] gate_setting_code, decade_bits, readout_address, model_digit;
  logic [7:0] rate_setting_ms;
  logic [4:0] pulse_v;
  logic [3:0] decade_select_ff;
  logic       main_gate_open_ff, accumulate_phase_ff, single_cycle_gate_ff;
  logic       rate_arm_ff, processor_start_ff, lamp_test_ff;
  logic       master_reset_ff, annunciator_recheck_ff;
  int         bad_count, checked, cyc, n_proc, n_rate, p0;

  cac_top #(.MS_TICK(TICK)) cac_top_inst (
    .core_clk, .nrst, .display_timer_enable, .fast_arm_request,
    .plugin_arm_request(pulse_v[0]), .external_arm_request(pulse_v[1]),
    .reset_button(pulse_v[2]), .remote_clear(pulse_v[3]),
    .plugin_clear(pulse_v[4]), .remote_mode, .totalize_select,
    .plugin_data_flag, .function_code, .display_position,
    .gate_setting_code, .rate_setting_ms, .decade_bits, .aux_lsb,
    .readout_address, .single_cycle_done, .multiplier_store_strobe,
    .decade_select_ff, .main_gate_open_ff, .accumulate_phase_ff,
    .single_cycle_gate_ff, .rate_arm_ff, .processor_start_ff,
    .lamp_test_ff, .master_reset_ff, .annunciator_recheck_ff
  );

  cac_scaler_model #(.STEP(STEP)) cac_scaler_model_inst (
    .core_clk, .gate_open(main_gate_open_ff),
    .decade_select(decade_select_ff), .decade_bits, .aux_lsb,
    .digit_ff(model_digit)
  );

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // Count pulses of rate arm and processor start
  always @(posedge core_clk) begin
    if (rate_arm_ff === 1'b1) n_rate++;
    if (processor_start_ff === 1'b1) n_proc++;
  end

  // Bounded wait for gate (0), master reset (1) or lamp test (2)
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    logic v;
    cyc = 0;
    v = ~lvl;
    while (v !== lvl && cyc < lim) begin
      @(posedge core_clk);
      #1;
      cyc++;
      v = (sel == 0) ? main_gate_open_ff :
          (sel == 1) ? master_reset_ff : lamp_test_ff;
    end
    if (v !== lvl) begin
      bad_count++;
      $display("ERROR wait %0d expected %0h seen %0h", sel, lvl, v);
    end
  endtask : wait_for

  // One-cycle pulse on an arm or clear pin
  task automatic pulse(input int i);
    @(posedge core_clk);
    pulse_v[i] <= 1'b1;
    @(posedge core_clk);
    pulse_v[i] <= 1'b0;
  endtask : pulse

  // New gate code resets, first-cycle arm opens, digit 5 closes
  task automatic gate_case(input logic [3:0] code);
    @(posedge core_clk);
    gate_setting_code <= code;
    wait_for(1, 1'b1, 10);
    wait_for(1, 1'b0, 40);
    wait_for(0, 1'b1, 5);
    `CHK("sel open", code, decade_select_ff)
    `CHK("acc open", 1'b1, accumulate_phase_ff)
    wait_for(0, 1'b0, 12 * STEP);
    `CHK("digit at close", 4'h5, model_digit)
    `CHK("acc closed", 1'b0, accumulate_phase_ff)
    `CHK("start at close", 1'b1, processor_start_ff)
    @(posedge core_clk);
    #1;
    `CHK("sel readout", readout_address, decade_select_ff)
    $display("done gate code %0h", code);
  endtask : gate_case

  // Display delay from enable rise to the next gate opening
  task automatic disp_case(input string nm, input logic rem, input logic fa,
                           input logic tot, input int ms);
    int lo;
    int hi;
    lo = (ms - 1) * TICK;
    hi = ms * TICK + 8;
    wait_for(0, 1'b0, 400);
    @(posedge core_clk);
    remote_mode <= rem;
    fast_arm_request <= fa;
    totalize_select <= tot;
    repeat (4) @(posedge core_clk);
    display_timer_enable <= 1'b1;
    wait_for(0, 1'b1, hi + 20);
    `CHK(nm, 1'b1, (cyc >= lo && cyc <= hi))
    `CHK(nm, 1'b1, rate_arm_ff)
    `CHK(nm, tot, processor_start_ff)
    @(posedge core_clk);
    display_timer_enable <= 1'b0;
    $display("done %s", nm);
  endtask : disp_case

  // Raise one reset source; src below 0 changes the function selector
  task automatic rst_case(input string nm, input int src, input logic rem,
                          input logic ex);
    logic seen;
    int   r0;
    seen = 1'b0;
    @(posedge core_clk);
    remote_mode <= rem;
    repeat (6) @(posedge core_clk);
    #1;
    r0 = n_rate;
    if (src < 0) begin
      @(posedge core_clk);
      function_code <= function_code + 3'h1;
    end else begin
      pulse(src);
    end
    repeat (12) begin
      @(posedge core_clk);
      #1;
      seen = seen | (master_reset_ff === 1'b1);
    end
    `CHK(nm, ex, seen)
    `CHK(nm, ex, (n_rate != r0))
    wait_for(1, 1'b0, 30);
    @(posedge core_clk);
    remote_mode <= 1'b0;
    repeat (60) @(posedge core_clk);
    $display("done %s", nm);
  endtask : rst_case

  // Print counts and verdict, then end the run
  task automatic stop_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Hang guard, well beyond the expected run time
  initial begin
    #200_000;
    bad_count++;
    $display("ERROR watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    {display_timer_enable, fast_arm_request, remote_mode} = 3'h0;
    {totalize_select, plugin_data_flag, single_cycle_done} = 3'h0;
    multiplier_store_strobe = 1'b0;
    pulse_v = 5'h00;
    function_code = 3'h1;
    display_position = 3'h2;
    gate_setting_code = 4'h3;
    rate_setting_ms = 8'h03;
    readout_address = 4'hA;
    // Power-on: reset held, then internal hold, then first-cycle arm
    repeat (9) @(posedge core_clk);
    #1;
    `CHK("por reset", 1'b1, master_reset_ff)
    `CHK("por gate", 1'b0, main_gate_open_ff)
    @(posedge core_clk);
    nrst <= 1'b1;
    wait_for(1, 1'b0, 20);
    `CHK("por length", 1'b1, (cyc >= 8 && cyc <= 13))
    wait_for(0, 1'b1, 3);
    `CHK("first arm", 1, cyc)
    $display("done power-on");
    gate_case(4'h2);
    gate_case(4'h3);
    // Plug-in arm with plug-in data: start from the rate arm only
    @(posedge core_clk);
    plugin_data_flag <= 1'b1;
    pulse(0);
    wait_for(0, 1'b1, 8);
    `CHK("pi rate arm", 1'b1, rate_arm_ff)
    `CHK("pi start", 1'b1, processor_start_ff)
    p0 = n_proc;
    wait_for(0, 1'b0, 12 * STEP);
    @(posedge core_clk);
    plugin_data_flag <= 1'b0;
    #1;
    `CHK("pi one start", 1, n_proc - p0)
    pulse(1);
    wait_for(0, 1'b1, 8);
    `CHK("ext arm", 1'b1, main_gate_open_ff)
    $display("done arm requests");
    disp_case("disp local", 1'b0, 1'b0, 1'b0, 3);
    disp_case("disp remote", 1'b1, 1'b0, 1'b0, 80);
    disp_case("disp fast", 1'b1, 1'b1, 1'b0, 5);
    disp_case("disp total", 1'b0, 1'b0, 1'b1, 80);
    // Annunciator flag set by the strobe, cleared by reset
    @(posedge core_clk);
    {fast_arm_request, totalize_select} <= 2'h0;
    multiplier_store_strobe <= 1'b1;
    @(posedge core_clk);
    multiplier_store_strobe <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("recheck set", 1'b1, annunciator_recheck_ff)
    rst_case("func local", -1, 1'b0, 1'b1);
    `CHK("recheck clr", 1'b0, annunciator_recheck_ff)
    rst_case("func remote", -1, 1'b1, 1'b0);
    rst_case("button local", 2, 1'b0, 1'b1);
    rst_case("button remote", 2, 1'b1, 1'b0);
    rst_case("rclr remote", 3, 1'b1, 1'b1);
    rst_case("piclr remote", 4, 1'b1, 1'b1);
    // Minimum gate: digit 5 ignored, single cycle done ends the gate
    @(posedge core_clk);
    gate_setting_code <= cac_pkg::MIN_GATE_CODE;
    wait_for(1, 1'b1, 8);
    wait_for(1, 1'b0, 20);
    wait_for(0, 1'b1, 4);
    `CHK("min gate out", 1'b1, single_cycle_gate_ff)
    repeat (6 * STEP) @(posedge core_clk);
    #1;
    `CHK("past digit 5", 1'b1, main_gate_open_ff)
    @(posedge core_clk);
    single_cycle_done <= 1'b1;
    wait_for(0, 1'b0, 4);
    @(posedge core_clk);
    single_cycle_done <= 1'b0;
    // Excess gate time: digit 8 arms, ten steps later abort
    pulse(1);
    cyc = 0;
    while (model_digit !== 4'h8 && cyc < 20 * STEP) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    wait_for(2, 1'b1, 12 * STEP);
    `CHK("trip time", 1'b1, (cyc >= TRIP && cyc <= TRIP + 4))
    `CHK("trip reset", 1'b1, master_reset_ff)
    wait_for(1, 1'b0, 20);
    @(posedge core_clk);
    gate_setting_code <= 4'h3;
    repeat (60) @(posedge core_clk);
    #1;
    `CHK("min gate off", 1'b0, single_cycle_gate_ff)
    `CHK("lamp cleared", 1'b0, lamp_test_ff)
    $display("done min gate and timeout");
    stop_test();
  end
endmodule : cac_top_bench
